// ---- core/ssfi_defines.vh ----
// shared constants of the shift/fifo instruction unit
// assumes: included by bare name from core files only
`ifndef SSFI_DEFINES_VH
`define SSFI_DEFINES_VH

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define SSFI_F_OPC    15:13
`define SSFI_F_DLY    12:8
`define SSFI_F_SEL    7:5
`define SSFI_F_CNT    4:0
`define SSFI_B_PULL   7
`define SSFI_B_IF     6
`define SSFI_B_BLK    5
`define SSFI_OP_IN    3'h2
`define SSFI_OP_OUT   3'h3
`define SSFI_OP_PP    3'h4

// ----------------------------------------
// source / destination codes
// ----------------------------------------
`define SSFI_S_PINS   3'h0
`define SSFI_S_X      3'h1
`define SSFI_S_Y      3'h2
`define SSFI_S_NULL   3'h3
`define SSFI_S_RES0   3'h4
`define SSFI_S_RES1   3'h5
`define SSFI_S_ISR    3'h6
`define SSFI_S_OSR    3'h7
`define SSFI_D_DIRS   3'h4
`define SSFI_D_PC     3'h5
`define SSFI_D_EXECUTE_SHIFTED_WORD   3'h7

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define SSFI_FULL     6'h20
`define SSFI_DLY_MAX  5'h05
`define SSFI_ONES     32'hFFFFFFFF

// ----------------------------------------
// register map (word indices, wb_adr_i[7:2])
// ----------------------------------------
`define SSFI_A_CTRL   6'h00
`define SSFI_A_PIN    6'h01
`define SSFI_A_STAT   6'h02
`define SSFI_A_X      6'h03
`define SSFI_A_Y      6'h04
`define SSFI_A_ISR    6'h05
`define SSFI_A_OSR    6'h06
`define SSFI_CTRL_RST 32'h00000000
`define SSFI_PIN_RST  32'h00000000

`endif

// ---- core/ssfi_core.v ----
// execution logic for the IN, OUT, PUSH and PULL instructions
// assumes: one 200 MHz clock, wishbone classic config port,
// fifo ports with valid/ready, instruction fetch outside
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ssfi_defines.vh"

module ssfi_core
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   // instruction in
   input  wire        instr_valid_i,
   input  wire [15:0] instr_i,
   output wire        instr_ready_o,
   // input pins
   input  wire [31:0] pins_i,
   // rx fifo fill side
   output wire        rx_valid_o,
   output wire [31:0] rx_data_o,
   input  wire        rx_ready_i,
   // tx fifo drain side
   input  wire        tx_valid_i,
   input  wire [31:0] tx_data_i,
   output wire        tx_ready_o,
   // out mapping, jump and execute_shifted_word
   output wire [31:0] pins_o,
   output wire [31:0] pins_mask_o,
   output wire        pins_stb_o,
   output wire        dirs_stb_o,
   output wire        jump_o,
   output wire [4:0]  jump_addr_o,
   output wire        execute_shifted_word_o,
   output wire [15:0] execute_shifted_word_word_o
);

// ----------------------------------------
// functions
// ----------------------------------------
function [5:0] cnt6;
   input [4:0] f;
   begin
      cnt6 = (f == 5'h00) ? `SSFI_FULL : {1'b0, f};
   end
endfunction

function [31:0] lowmask;
   input [5:0] n;
   begin
      lowmask = ~(`SSFI_ONES << n);
   end
endfunction

function [5:0] sat;
   input [5:0] a;
   input [5:0] b;
   reg   [6:0] s;
   begin
      s   = {1'b0, a} + {1'b0, b};
      sat = (s > {1'b0, `SSFI_FULL}) ? `SSFI_FULL : s[5:0];
   end
endfunction

function [31:0] rotl;
   input [31:0] v;
   input [4:0]  n;
   reg   [63:0] t;
   begin
      t    = {v, v} << n;
      rotl = t[63:32];
   end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg  [31:0] ctrl_r;
reg  [31:0] pin_r;
reg  [31:0] isr_r;
reg  [31:0] isr_nxt;
reg  [5:0]  isr_cnt_r;
reg  [5:0]  isr_cnt_nxt;
reg  [31:0] osr_r;
reg  [31:0] osr_nxt;
reg  [5:0]  osr_cnt_r;
reg  [5:0]  osr_cnt_nxt;
reg  [31:0] x_r;
reg  [31:0] x_nxt;
reg  [31:0] y_r;
reg  [31:0] y_nxt;
reg         rx_stall_debug_flag_r;
reg  [4:0]  delay_r;
reg  [4:0]  delay_nxt;
reg         execute_shifted_word_r;
reg  [15:0] execute_shifted_word_word_r;
reg         jump_r;
reg  [4:0]  jump_addr_r;
reg  [31:0] pins_r;
reg  [31:0] mask_r;
reg         pins_stb_r;
reg         dirs_stb_r;
reg         ack_r;
reg  [31:0] dat_r;

reg         stall;
reg         rx_push;
reg         tx_pop;
reg         flag_set;
reg         pin_stb;
reg         dir_stb;
reg         jump;
reg         execute_shifted_word_set;
reg  [31:0] rx_word;
reg  [31:0] src;
reg  [31:0] odata;
reg  [31:0] ow;
reg  [5:0]  oc;
reg  [31:0] sh;
reg  [5:0]  sc;

// ----------------------------------------
// configuration fields
// ----------------------------------------
wire        in_shift_direction  = ctrl_r[0];
wire        out_shift_direction = ctrl_r[1];
wire        auto_push           = ctrl_r[2];
wire        auto_pull           = ctrl_r[3];
wire [5:0]  auto_push_threshold = cnt6(ctrl_r[8:4]);
wire [5:0]  auto_pull_threshold = cnt6(ctrl_r[13:9]);
wire [2:0]  sideset_count       = ctrl_r[16:14];
wire [4:0]  input_pin_base      = pin_r[4:0];
wire [4:0]  out_pin_base        = pin_r[9:5];
wire [5:0]  out_pin_count       = pin_r[15:10];

// ----------------------------------------
// instruction selection
// ----------------------------------------
// an execute_shifted_word word always runs before the next fetched one
wire [15:0] cur   = execute_shifted_word_r ? execute_shifted_word_word_r : instr_i;
wire        go    = (execute_shifted_word_r | instr_valid_i) & (delay_r == 5'h00);
wire [5:0]  cnt   = cnt6(cur[`SSFI_F_CNT]);
wire [2:0]  sel   = cur[`SSFI_F_SEL];
// side-set takes the top bits; delay keeps the rest
wire [4:0]  dmask = (sideset_count > `SSFI_DLY_MAX) ? 5'h00 :
                    (5'h1F >> sideset_count);
wire [4:0]  dly   = cur[`SSFI_F_DLY] & dmask;

// ----------------------------------------
// wishbone decode
// ----------------------------------------
wire [5:0]  widx  = wb_adr_i[7:2];
wire        wr    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

function [31:0] merge;
   input [31:0] old;
   input [31:0] nw;
   input [3:0]  be;
   integer i;
   begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
         if (be[i])
            merge[i*8 +: 8] = nw[i*8 +: 8];
   end
endfunction

// ----------------------------------------
// execution
// ----------------------------------------
always @*
begin
   isr_nxt     = isr_r;
   isr_cnt_nxt = isr_cnt_r;
   osr_nxt     = osr_r;
   osr_cnt_nxt = osr_cnt_r;
   x_nxt       = (wr && widx == `SSFI_A_X) ?
                 merge(x_r, wb_dat_i, wb_sel_i) : x_r;
   y_nxt       = (wr && widx == `SSFI_A_Y) ?
                 merge(y_r, wb_dat_i, wb_sel_i) : y_r;
   stall    = 1'b0;
   rx_push  = 1'b0;
   tx_pop   = 1'b0;
   flag_set = 1'b0;
   pin_stb  = 1'b0;
   dir_stb  = 1'b0;
   jump     = 1'b0;
   execute_shifted_word_set = 1'b0;
   rx_word  = isr_r;
   src      = 32'h00000000;
   odata    = 32'h00000000;
   ow       = osr_r;
   oc       = osr_cnt_r;
   sh       = 32'h00000000;
   sc       = 6'h00;
   if (go)
   begin
      case (cur[`SSFI_F_OPC])
         `SSFI_OP_IN:
         begin
            case (sel)
               `SSFI_S_PINS: src = rotl(pins_i, 5'h00 - input_pin_base);
               `SSFI_S_X:    src = x_r;
               `SSFI_S_Y:    src = y_r;
               `SSFI_S_ISR:  src = isr_r;
               `SSFI_S_OSR:  src = osr_r;
               default:      src = 32'h00000000;
            endcase
            src = src & lowmask(cnt);
            if (sel != `SSFI_S_RES0 && sel != `SSFI_S_RES1)
            begin
               // shift first, then drop source into the gap
               if (in_shift_direction)
                  sh = (isr_r >> cnt) | (src << (`SSFI_FULL - cnt));
               else
                  sh = (isr_r << cnt) | src;
               sc = sat(isr_cnt_r, cnt);
               isr_nxt     = sh;
               isr_cnt_nxt = sc;
               if (auto_push && sc >= auto_push_threshold)
               begin
                  if (!rx_ready_i)
                  begin
                     stall       = 1'b1;
                     flag_set    = 1'b1;
                     isr_nxt     = isr_r;
                     isr_cnt_nxt = isr_cnt_r;
                  end
                  else
                  begin
                     rx_push     = 1'b1;
                     rx_word     = sh;
                     isr_nxt     = 32'h00000000;
                     isr_cnt_nxt = 6'h00;
                  end
               end
            end
         end
         `SSFI_OP_OUT:
         begin
            // refill before shifting so the OUT still takes one cycle
            if (auto_pull && osr_cnt_r >= auto_pull_threshold)
            begin
               if (!tx_valid_i)
                  stall = 1'b1;
               else
               begin
                  tx_pop = 1'b1;
                  ow     = tx_data_i;
                  oc     = 6'h00;
               end
            end
            if (!stall)
            begin
               if (out_shift_direction)
               begin
                  odata   = ow & lowmask(cnt);
                  osr_nxt = ow >> cnt;
               end
               else
               begin
                  odata   = ow >> (`SSFI_FULL - cnt);
                  osr_nxt = ow << cnt;
               end
               osr_cnt_nxt = sat(oc, cnt);
               case (sel)
                  `SSFI_S_PINS: pin_stb = 1'b1;
                  `SSFI_S_X:    x_nxt   = odata;
                  `SSFI_S_Y:    y_nxt   = odata;
                  `SSFI_D_DIRS: dir_stb = 1'b1;
                  `SSFI_D_PC:   jump    = 1'b1;
                  `SSFI_S_ISR:
                  begin
                     isr_nxt     = odata;
                     isr_cnt_nxt = cnt;
                  end
                  `SSFI_D_EXECUTE_SHIFTED_WORD: execute_shifted_word_set = 1'b1;
                  default:      odata    = odata;
               endcase
            end
         end
         `SSFI_OP_PP:
         begin
            if (!cur[`SSFI_B_PULL])
            begin
               if (!(cur[`SSFI_B_IF] &&
                     isr_cnt_r < auto_push_threshold))
               begin
                  if (!rx_ready_i)
                  begin
                     flag_set = 1'b1;
                     stall    = cur[`SSFI_B_BLK];
                  end
                  else
                     rx_push = 1'b1;
                  if (!stall)
                  begin
                     isr_nxt     = 32'h00000000;
                     isr_cnt_nxt = 6'h00;
                  end
               end
            end
            else if (!(auto_pull && osr_cnt_r == 6'h00) &&
                     !(cur[`SSFI_B_IF] &&
                       osr_cnt_r < auto_pull_threshold))
            begin
               if (tx_valid_i)
               begin
                  tx_pop      = 1'b1;
                  osr_nxt     = tx_data_i;
                  osr_cnt_nxt = 6'h00;
               end
               else if (cur[`SSFI_B_BLK])
                  stall = 1'b1;
               else
               begin
                  osr_nxt     = x_r;
                  osr_cnt_nxt = 6'h00;
               end
            end
         end
         default:
            stall = 1'b0;
      endcase
   end
   // delay starts only once the instruction completes
   if (go && !stall)
      delay_nxt = execute_shifted_word_set ? 5'h00 : dly;
   else if (delay_r != 5'h00)
      delay_nxt = delay_r - 5'h01;
   else
      delay_nxt = 5'h00;
end

// ----------------------------------------
// registers
// ----------------------------------------
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ctrl_r                <= `SSFI_CTRL_RST;
      pin_r                 <= `SSFI_PIN_RST;
      isr_r                 <= 32'h00000000;
      isr_cnt_r             <= 6'h00;
      osr_r                 <= 32'h00000000;
      osr_cnt_r             <= `SSFI_FULL;
      x_r                   <= 32'h00000000;
      y_r                   <= 32'h00000000;
      rx_stall_debug_flag_r <= 1'b0;
      delay_r               <= 5'h00;
      execute_shifted_word_r                <= 1'b0;
      execute_shifted_word_word_r           <= 16'h0000;
      jump_r                <= 1'b0;
      jump_addr_r           <= 5'h00;
      pins_r                <= 32'h00000000;
      mask_r                <= 32'h00000000;
      pins_stb_r            <= 1'b0;
      dirs_stb_r            <= 1'b0;
   end
   else
   begin
      if (wr && widx == `SSFI_A_CTRL)
         ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
      if (wr && widx == `SSFI_A_PIN)
         pin_r <= merge(pin_r, wb_dat_i, wb_sel_i);
      isr_r     <= isr_nxt;
      isr_cnt_r <= isr_cnt_nxt;
      osr_r     <= osr_nxt;
      osr_cnt_r <= osr_cnt_nxt;
      x_r       <= x_nxt;
      y_r       <= y_nxt;
      // a new stall event beats a clear in the same cycle
      rx_stall_debug_flag_r <= flag_set | (rx_stall_debug_flag_r &
         ~(wr && widx == `SSFI_A_STAT && wb_sel_i[0] && wb_dat_i[0]));
      delay_r <= delay_nxt;
      if (execute_shifted_word_set)
      begin
         execute_shifted_word_r      <= 1'b1;
         execute_shifted_word_word_r <= odata[15:0];
      end
      else if (go && !stall)
         execute_shifted_word_r <= 1'b0;
      jump_r     <= jump;
      pins_stb_r <= pin_stb;
      dirs_stb_r <= dir_stb;
      if (jump)
         jump_addr_r <= odata[4:0];
      if (pin_stb || dir_stb)
      begin
         pins_r <= rotl(odata, out_pin_base);
         mask_r <= rotl(lowmask(out_pin_count), out_pin_base);
      end
   end
end

// ----------------------------------------
// wishbone slave
// ----------------------------------------
// one wait state: ack one edge after the request, data with it
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
   end
   else
   begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      case (widx)
         `SSFI_A_CTRL: dat_r <= ctrl_r;
         `SSFI_A_PIN:  dat_r <= pin_r;
         `SSFI_A_STAT: dat_r <= {10'h000, osr_cnt_r, 2'h0, isr_cnt_r,
                                 7'h00, rx_stall_debug_flag_r};
         `SSFI_A_X:    dat_r <= x_r;
         `SSFI_A_Y:    dat_r <= y_r;
         `SSFI_A_ISR:  dat_r <= isr_r;
         `SSFI_A_OSR:  dat_r <= osr_r;
         default:      dat_r <= 32'h00000000;
      endcase
   end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign wb_dat_o      = dat_r;
assign wb_ack_o      = ack_r;
assign instr_ready_o = go & ~stall & ~execute_shifted_word_r;
assign rx_valid_o    = rx_push;
assign rx_data_o     = rx_word;
assign tx_ready_o    = tx_pop;
assign pins_o        = pins_r;
assign pins_mask_o   = mask_r;
assign pins_stb_o    = pins_stb_r;
assign dirs_stb_o    = dirs_stb_r;
assign jump_o        = jump_r;
assign jump_addr_o   = jump_addr_r;
assign execute_shifted_word_o        = execute_shifted_word_r;
assign execute_shifted_word_word_o   = execute_shifted_word_word_r;

endmodule // ssfi_core

// ---- verif/ssfi_core_props.sv ----
// concurrent checks on the ports of the shift/fifo instruction core
// assumes: bound into ssfi_core by the bench, one clock, sync reset
`timescale 1ns/1ps

module ssfi_core_props
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_ack_o,
   // instruction port
   input  wire        instr_valid_i,
   input  wire [15:0] instr_i,
   input  wire        instr_ready_o,
   // fifo handshakes
   input  wire        rx_valid_o,
   input  wire        rx_ready_i,
   input  wire        tx_valid_i,
   input  wire        tx_ready_o,
   // out side effects
   input  wire        pins_stb_o,
   input  wire        jump_o,
   input  wire        execute_shifted_word_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------------
   // decode helpers
   // ---------------------------------------
   wire       acc = instr_valid_i && instr_ready_o;
   wire [2:0] op  = instr_i[15:13];
   wire [2:0] sel = instr_i[7:5];

   // ---------------------------------------
   // assertions
   // ---------------------------------------
   a_ack_one_wait: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_rx_gated: assert property (rx_valid_o |-> rx_ready_i)
      else $error("push into full rx fifo");
   a_tx_gated: assert property (tx_ready_o |-> tx_valid_i)
      else $error("pop from empty tx fifo");
   a_execute_shifted_word_holds: assert property (execute_shifted_word_o |-> !instr_ready_o)
      else $error("fetch taken during execute_shifted_word cycle");
   a_execute_shifted_word_next: assert property (
      acc && op == 3'h3 && sel == 3'h7 |=> execute_shifted_word_o)
      else $error("shifted word not executed next cycle");
   a_push_stall: assert property (
      instr_valid_i && op == 3'h4 && sel == 3'h1 && !rx_ready_i
      |-> !instr_ready_o)
      else $error("blocking push completed on full fifo");
   a_push_fires: assert property (
      acc && op == 3'h4 && sel == 3'h1 |-> rx_valid_o)
      else $error("push completed without fifo write");
   a_delay_idle: assert property (
      acc && op == 3'h2 && instr_i[12:8] == 5'h02
      |=> !instr_ready_o [*2])
      else $error("delay cycles not inserted");
   a_pins_pulse: assert property (
      acc && op == 3'h3 && sel == 3'h0 |=> pins_stb_o)
      else $error("out to pins gave no strobe");
   a_jump_pulse: assert property (
      acc && op == 3'h3 && sel == 3'h5 |=> jump_o)
      else $error("out to pc gave no jump");

   c_push: cover property (acc && op == 3'h4);
   c_execute_shifted_word: cover property (execute_shifted_word_o);
   c_auto_push: cover property (acc && op == 3'h2 && rx_valid_o);
endmodule // ssfi_core_props

// ---- verif/ssfi_fifo_model.sv ----
// system side of the rx and tx fifos, as seen by the core
// assumes: bench fills tx and frees rx space through the tasks below
`timescale 1ns/1ps

module ssfi_fifo_model
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // rx fifo, filled by the core
   input  wire        rx_valid_i,
   input  wire [31:0] rx_data_i,
   output reg         rx_ready_o,
   // tx fifo, drained by the core
   input  wire        tx_ready_i,
   output reg         tx_valid_o,
   output reg  [31:0] tx_data_o
);
   logic [31:0] txq[$];
   logic [31:0] rxq[$];
   logic [31:0] last_r = 32'h0;
   int          room   = 8;

   // an empty fifo shows no stale head word: data lines are inverted
   task show;
      begin
         tx_valid_o <= (txq.size() != 0);
         tx_data_o  <= (txq.size() != 0) ? txq[0] : ~last_r;
         rx_ready_o <= (room > 0);
      end
   endtask

   task put_tx(input [31:0] w);
      begin
         txq.push_back(w);
         show();
      end
   endtask

   task set_room(input int n);
      begin
         room = n;
         show();
      end
   endtask

   initial show();

   always @(posedge clk_i)
   begin
      if (!rst_i && tx_valid_o && tx_ready_i)
         last_r = txq.pop_front();
      if (!rst_i && rx_valid_i && rx_ready_o)
      begin
         rxq.push_back(rx_data_i);
         room = room - 1;
      end
      show();
   end
endmodule // ssfi_fifo_model

// ---- verif/ssfi_core_tb_top.sv ----
// self-checking bench: wishbone config plus instruction sequences
// assumes: core, fifo model and checker compiled before this file
`timescale 1ns/1ps

module ssfi_core_tb_top;
   logic        clk_i         = 1'b0;
   logic        rst_i         = 1'b1;
   logic        wb_cyc_i      = 1'b0;
   logic        wb_stb_i      = 1'b0;
   logic        wb_we_i       = 1'b0;
   logic [7:0]  wb_adr_i      = 8'h00;
   logic [3:0]  wb_sel_i      = 4'h0;
   logic [31:0] pins_i        = 32'h0000000B;
   logic [31:0] wb_dat_i      = 32'h00000000;
   logic        instr_valid_i = 1'b0;
   logic [15:0] instr_i       = 16'h0000;
   logic [31:0] q;
   wire  [31:0] wb_dat_o, rx_data_o, tx_data_i, pins_o, pins_mask_o;
   wire  [15:0] execute_shifted_word_word_o;
   wire  [4:0]  jump_addr_o;
   wire         wb_ack_o, instr_ready_o, rx_valid_o, rx_ready_i;
   wire         tx_valid_i, tx_ready_o, pins_stb_o, dirs_stb_o;
   wire         jump_o, execute_shifted_word_o;
   int          errors     = 0;
   int          num_checks = 0;

   always #2.5 clk_i = ~clk_i;

   ssfi_core i_ssfi_core (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(instr_ready_o),
      .pins_i(pins_i), .rx_valid_o(rx_valid_o),
      .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
      .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
      .tx_ready_o(tx_ready_o), .pins_o(pins_o),
      .pins_mask_o(pins_mask_o), .pins_stb_o(pins_stb_o),
      .dirs_stb_o(dirs_stb_o), .jump_o(jump_o),
      .jump_addr_o(jump_addr_o), .execute_shifted_word_o(execute_shifted_word_o),
      .execute_shifted_word_word_o(execute_shifted_word_word_o));

   ssfi_fifo_model i_ssfi_fifo_model (
      .clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_o),
      .rx_data_i(rx_data_o), .rx_ready_o(rx_ready_i),
      .tx_ready_i(tx_ready_o), .tx_valid_o(tx_valid_i),
      .tx_data_o(tx_data_i));

   // ---------------------------------------
   // checking and closing
   // ---------------------------------------
   task stop_test;
      begin
         if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks++;
         if (got !== exp)
         begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // ---------------------------------------
   // bus and instruction drivers
   // ---------------------------------------
   task wb(input [7:0] a, input w, input [31:0] d, input [3:0] s);
      int n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= w;
         wb_sel_i <= s;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (wb_ack_o !== 1'b1 && n < 20);
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         if (wb_ack_o !== 1'b1)
         begin
            errors++;
            stop_test;
         end
         @(posedge clk_i);
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      wb(a, 1'b1, d, 4'hF);
   endtask

   task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         wb(a, 1'b0, 32'h00000000, 4'hF);
         chk(q & m, e);
      end
   endtask

   // k=1: expect a stall, then free rx space; k=2: stall, then feed tx
   task run(input [15:0] ins, input [1:0] k, input [31:0] w);
      int n;
      begin
         instr_valid_i <= 1'b1;
         instr_i       <= ins;
         #1;
         if (k != 2'h0)
         begin
            repeat (3)
            begin
               chk({31'h0, instr_ready_o}, 32'h0);
               @(posedge clk_i);
               #1;
            end
            if (k == 2'h1)
               i_ssfi_fifo_model.set_room(1);
            else
               i_ssfi_fifo_model.put_tx(w);
            #1;
         end
         n = 0;
         while (instr_ready_o !== 1'b1 && n < 40)
         begin
            @(posedge clk_i);
            #1;
            n++;
         end
         if (instr_ready_o !== 1'b1)
         begin
            errors++;
            stop_test;
         end
         @(posedge clk_i);
         instr_valid_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task ex(input [15:0] ins);
      run(ins, 2'h0, 32'h00000000);
   endtask

   task rxchk(input [31:0] e);
      chk(i_ssfi_fifo_model.rxq.size() > 0 ?
          i_ssfi_fifo_model.rxq.pop_front() : ~e, e);
   endtask

   // ---------------------------------------
   // main sequence
   // ---------------------------------------
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(8'h00, 32'hFFFFFFFF, 32'h00000000);
      rchk(8'h08, 32'hFFFFFFFF, 32'h00200000);
      rchk(8'hFC, 32'hFFFFFFFF, 32'h00000000);
      wr(8'h0C, 32'h12345678);
      wr(8'h10, 32'hCAFE1234);
      wb(8'h10, 1'b1, 32'hFFFFF00D, 4'h3);
      wr(8'h14, 32'hFFFFFFFF);
      rchk(8'h14, 32'hFFFFFFFF, 32'h00000000);
      ex(16'h4228);
      ex(16'h4004);
      rchk(8'h14, 32'hFFFFFFFF, 32'h0000078B);
      ex(16'h4040);
      ex(16'h4064);
      ex(16'h4084);
      ex(16'h40A4);
      ex(16'h40C4);
      ex(16'h40E8);
      rchk(8'h14, 32'hFFFFFFFF, 32'hF00D0000);
      rchk(8'h08, 32'h003F3F00, 32'h00202000);
      wr(8'h00, 32'h00000001);
      ex(16'h4028);
      rchk(8'h14, 32'hFFFFFFFF, 32'h78F00D00);
      ex(16'h8020);
      rxchk(32'h78F00D00);
      rchk(8'h14, 32'hFFFFFFFF, 32'h00000000);
      i_ssfi_fifo_model.set_room(0);
      ex(16'h4028);
      ex(16'h8000);
      chk(i_ssfi_fifo_model.rxq.size(), 32'h0);
      rchk(8'h14, 32'hFFFFFFFF, 32'h00000000);
      rchk(8'h08, 32'h00000001, 32'h00000001);
      wr(8'h08, 32'h00000001);
      rchk(8'h08, 32'h00000001, 32'h00000000);
      ex(16'h4028);
      run(16'h8020, 2'h1, 32'h0);
      rxchk(32'h78000000);
      wr(8'h00, 32'h00000000);
      run(16'h80A0, 2'h2, 32'hA5C30F96);
      rchk(8'h18, 32'hFFFFFFFF, 32'hA5C30F96);
      ex(16'h6028);
      rchk(8'h0C, 32'hFFFFFFFF, 32'h000000A5);
      rchk(8'h18, 32'hFFFFFFFF, 32'hC30F9600);
      wr(8'h00, 32'h00000002);
      ex(16'h604C);
      rchk(8'h10, 32'hFFFFFFFF, 32'h00000600);
      rchk(8'h08, 32'h003F0000, 32'h00140000);
      ex(16'h60C5);
      rchk(8'h14, 32'hFFFFFFFF, 32'h00000019);
      rchk(8'h08, 32'h003F3F00, 32'h00190500);
      wr(8'h04, 32'h00001080);
      ex(16'h6004);
      chk(pins_o, 32'h00000070);
      chk(pins_mask_o, 32'h000000F0);
      ex(16'h6084);
      chk(pins_o, 32'h00000080);
      ex(16'h60A5);
      chk({27'h0, jump_addr_o}, 32'h00000001);
      run(16'h80A0, 2'h2, 32'h00004028);
      ex(16'h63F0);
      chk({16'h0, execute_shifted_word_word_o}, 32'h00004028);
      rchk(8'h14, 32'hFFFFFFFF, 32'h000019A5);
      ex(16'h8080);
      rchk(8'h18, 32'hFFFFFFFF, 32'h000000A5);
      i_ssfi_fifo_model.put_tx(32'h0BADF00D);
      ex(16'h80E0);
      rchk(8'h18, 32'hFFFFFFFF, 32'h000000A5);
      ex(16'h6060);
      ex(16'h80E0);
      rchk(8'h18, 32'hFFFFFFFF, 32'h0BADF00D);
      // autopull, threshold 8, both directions left
      wr(8'h00, 32'h00001008);
      i_ssfi_fifo_model.put_tx(32'h3C0000FF);
      ex(16'h80A0);
      rchk(8'h18, 32'hFFFFFFFF, 32'h0BADF00D);
      ex(16'h6028);
      ex(16'h6048);
      rchk(8'h10, 32'hFFFFFFFF, 32'h0000003C);
      run(16'h6048, 2'h2, 32'h5A000000);
      rchk(8'h10, 32'hFFFFFFFF, 32'h0000005A);
      rchk(8'h08, 32'h003F0000, 32'h00080000);
      // autopush, threshold 8
      wr(8'h00, 32'h00000084);
      i_ssfi_fifo_model.set_room(8);
      wr(8'h08, 32'h00000001);
      ex(16'h60C3);
      ex(16'h4025);
      rxchk(32'h0000000B);
      rchk(8'h14, 32'hFFFFFFFF, 32'h00000000);
      rchk(8'h08, 32'h00003F00, 32'h00000000);
      ex(16'h8060);
      chk(i_ssfi_fifo_model.rxq.size(), 32'h0);
      i_ssfi_fifo_model.set_room(0);
      ex(16'h60C3);
      run(16'h4025, 2'h1, 32'h0);
      rxchk(32'h0000000B);
      rchk(8'h08, 32'h00000001, 32'h00000001);
      wr(8'h04, 32'h00000004);
      pins_i <= 32'h000000B0;
      ex(16'h4004);
      rchk(8'h14, 32'hFFFFFFFF, 32'h0000000B);
      stop_test;
   end
endmodule // ssfi_core_tb_top

bind ssfi_core ssfi_core_props i_ssfi_core_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i),
   .instr_ready_o(instr_ready_o), .rx_valid_o(rx_valid_o),
   .rx_ready_i(rx_ready_i), .tx_valid_i(tx_valid_i),
   .tx_ready_o(tx_ready_o), .pins_stb_o(pins_stb_o), .jump_o(jump_o),
   .execute_shifted_word_o(execute_shifted_word_o));
